/* hdl/adc_mode_and_channel_sequencer.sv */
// What this block does
// RULE1 - mode field picks continuous or single conversion
// RULE2 - mode field also picks standby, power-down, calibrations
// RULE3 - control holds clock source and reference enable
// RULE4 - reference source comes from active channel's setup
// RULE5 - interface register: word length, checksum, status, continuous
// RULE6 - channel MSB enables it; only enabled channels convert; a mode write mid-run with none enabled still converts channel 15
// RULE7 - sequencer ascends through enabled channels, then wraps
// RULE8 - any channel maps to any of eight setups
// RULE9 - host programs only setups it uses; coefficients optional
// RULE10 - setup words at 0x20, 0x28, 0x38, 0x30 plus n
// RULE11 - reference enable is bit 15, set at power-up
// RULE12 - single mode converts once, then stops
`timescale 1ns/10ps
`include "adc_seq_defs.svh"

module adc_mode_and_channel_sequencer
  import adc_seq_pkg::*;
#(
  parameter logic [23:0] SCALE_RESET = `RST_SCALE_COEF
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // converter control
  output conv_out_t        conv_out,
  output iface_out_t       iface_out
);

  typedef struct packed {
    logic [15:0]       conv_ctrl;
    logic [15:0]       iface;
    logic [15:0][15:0] chan;
    logic [7:0][1:0]   ref_sel;
    seq_state_t        seq;
    logic [3:0]        cur_ch;
    logic [15:0]       cnt;
    logic              done;
    logic              ready_flag;
    logic [31:0]       rdata;
    logic              rd_mem;
  } core_state_t;

  core_state_t st;
  core_state_t next_st;

  // shadow selects wake up as the setup words' own reset value says
  localparam logic [23:0] SETUP_RESET = `RST_SETUP_CFG;

  logic [5:0]  idx;
  logic        setup_phase;
  logic        wr_access;
  logic        rd_access;
  logic        mapped;
  logic        in_bank;
  logic        wr_conv;
  logic        wr_chan;
  logic [15:0] en_mask;
  logic [3:0]  nxt_ch;
  logic [3:0]  low_ch;
  logic [23:0] bank_rd;
  conv_mode_t  cur_mode;
  conv_mode_t  new_mode;

  // next enabled channel above cur, wrapping past 15
  function automatic logic [3:0] next_enabled(input logic [15:0] en,
                                              input logic [3:0]  cur);
    logic [3:0] pick;
    logic       found;
    logic [4:0] k;
    pick  = cur;
    found = 1'b0;
    k     = 5'h00;
    for (int i = 1; i <= 16; i++) begin
      k = 5'(cur) + 5'(i);
      if (!found && en[k[3:0]]) begin
        pick  = k[3:0];
        found = 1'b1;
      end
    end
    return pick;
  endfunction

  function automatic logic is_mapped(input logic [5:0] a);
    return (a <= `IDX_IFACE_CFG) || (a >= `IDX_CHAN_BASE);
  endfunction

  function automatic logic starts_run(input conv_mode_t m);
    return (m != MODE_STANDBY) && (m != MODE_POWER_DOWN);
  endfunction

  assign idx         = paddr[7:2];
  assign setup_phase = psel && !penable;
  assign mapped      = is_mapped(idx) && (paddr[1:0] == 2'b00);
  assign wr_access   = psel && penable && pwrite && mapped;
  assign rd_access   = psel && penable && !pwrite && mapped;
  assign in_bank     = idx >= `IDX_SETUP_CFG;
  assign wr_conv     = wr_access && (idx == `IDX_CONV_CTRL);
  assign wr_chan     = wr_access && (idx[5:4] == 2'b01);
  assign cur_mode    = conv_mode_t'(st.conv_ctrl[`CC_MODE_HI:`CC_MODE_LO]);
  assign new_mode    = conv_mode_t'(pwdata[`CC_MODE_HI:`CC_MODE_LO]);
  assign nxt_ch      = next_enabled(en_mask, st.cur_ch);
  assign low_ch      = next_enabled(en_mask, 4'hf);

  always_comb begin
    for (int i = 0; i < 16; i++) begin
      en_mask[i] = st.chan[i][`CH_EN];
    end
  end

  // setup, filter, zero and scale words of all eight setups
  setup_bank #(
    .SCALE_RESET (SCALE_RESET)
  ) u_bank (
    .pclk    (pclk),
    .presetn (presetn),
    .wr_en   (wr_access && in_bank), // RULE10
    .wr_addr (idx[4:0]),
    .wr_data (pwdata[23:0]),
    .rd_addr (idx[4:0]),
    .rd_data (bank_rd)
  );

  always_comb begin
    next_st      = st;
    next_st.done = 1'b0;

    // read data captured in the setup phase so the access needs no wait
    if (setup_phase) begin
      next_st.rd_mem = in_bank && !pwrite;
      next_st.rdata  = 32'h00000000;
      if (idx == `IDX_STATUS) begin
        next_st.rdata = {26'h0, st.ready_flag, (st.seq == SEQ_RUN), st.cur_ch};
      end else if (idx == `IDX_CONV_CTRL) begin
        next_st.rdata = {16'h0000, st.conv_ctrl};
      end else if (idx == `IDX_IFACE_CFG) begin
        next_st.rdata = {16'h0000, st.iface};
      end else if (idx[5:4] == 2'b01) begin
        next_st.rdata = {16'h0000, st.chan[idx[3:0]]};
      end
    end

    if (rd_access && (idx == `IDX_STATUS)) begin
      next_st.ready_flag = 1'b0;
    end

    if (wr_access) begin
      if (idx == `IDX_CONV_CTRL) begin
        next_st.conv_ctrl = pwdata[15:0]; // RULE3
      end else if (idx == `IDX_IFACE_CFG) begin
        next_st.iface = pwdata[15:0]; // RULE5
      end else if (idx[5:4] == 2'b01) begin
        next_st.chan[idx[3:0]] = pwdata[15:0]; // RULE8
      end else if (idx[5:3] == 3'b100) begin
        // shadow of each setup's reference select for the live mux
        next_st.ref_sel[idx[2:0]] = pwdata[`SU_REF_HI:`SU_REF_LO]; // RULE4
      end
    end

    case (st.seq)
      SEQ_IDLE: begin
        // a mode write is the request; only enabled channels run
        if (wr_conv && starts_run(new_mode) && (en_mask != 16'h0000)) begin // RULE6
          next_st.seq    = SEQ_RUN;
          next_st.cur_ch = low_ch;
          next_st.cnt    = `CONV_CYCLES - 16'd1;
        end
      end
      SEQ_RUN: begin
        if (wr_conv && !starts_run(new_mode)) begin
          next_st.seq = SEQ_IDLE; // RULE2
        end else if (wr_conv) begin
          next_st.cur_ch = low_ch;
          next_st.cnt    = `CONV_CYCLES - 16'd1;
        end else if (st.cnt != 16'd0) begin
          next_st.cnt = st.cnt - 16'd1;
        end else begin
          next_st.done       = 1'b1;
          next_st.ready_flag = 1'b1;
          if ((cur_mode == MODE_CONTINUOUS) && (en_mask != 16'h0000)) begin // RULE1
            next_st.cur_ch = nxt_ch; // RULE7
            next_st.cnt    = `CONV_CYCLES - 16'd1;
          end else begin
            // single and calibration runs wait for the next mode write
            next_st.seq = SEQ_IDLE; // RULE12
          end
        end
      end
      default: begin
        next_st.seq = SEQ_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st            <= '0;
      st.conv_ctrl  <= `RST_CONV_CTRL; // RULE11
      st.iface      <= `RST_IFACE_CFG;
      st.chan       <= {16{`RST_CHAN}};
      st.ref_sel    <= {8{SETUP_RESET[`SU_REF_HI:`SU_REF_LO]}};
      st.seq        <= SEQ_IDLE;
    end else begin
      st <= next_st;
    end
  end

  // bus answers in the access phase with no wait state
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata  = st.rd_mem ? {8'h00, bank_rd} : st.rdata;

  always_comb begin
    conv_out.mode                  = cur_mode;
    conv_out.clock_source_select   = st.conv_ctrl[`CC_CLK_HI:`CC_CLK_LO];
    conv_out.ref_enable            = st.conv_ctrl[`CC_REF_EN];
    conv_out.conceal_settling_wait = st.conv_ctrl[`CC_HIDE];
    conv_out.one_cycle_settling    = st.conv_ctrl[`CC_ONE_CYC];
    conv_out.settle_delay          = st.conv_ctrl[`CC_DELAY_HI:`CC_DELAY_LO];
    conv_out.active_channel        = st.cur_ch;
    conv_out.active_setup          = st.chan[st.cur_ch][`CH_SETUP_HI:`CH_SETUP_LO];
    conv_out.ref_select            = st.ref_sel[conv_out.active_setup]; // RULE4
    conv_out.pos_input             = st.chan[st.cur_ch][`CH_POS_HI:`CH_POS_LO];
    conv_out.neg_input             = st.chan[st.cur_ch][`CH_NEG_HI:`CH_NEG_LO];
    conv_out.converting            = (st.seq == SEQ_RUN);
    conv_out.conversion_done       = st.done;
    conv_out.standby               = (cur_mode == MODE_STANDBY);
    conv_out.power_down            = (cur_mode == MODE_POWER_DOWN);
    conv_out.calibrating           = cur_mode[2] && (st.seq == SEQ_RUN);
  end

  always_comb begin
    iface_out.short_word_length        = st.iface[`IF_SHORT_WORD_LENGTH];
    iface_out.checksum_mode            = st.iface[`IF_CRC_HI:`IF_CRC_LO];
    iface_out.append_status            = st.iface[`IF_DATA_STAT];
    iface_out.continuous_read_enable   = st.iface[`IF_CONT_READ];
    iface_out.reg_check                = st.iface[`IF_REG_CHECK];
    iface_out.alternate_sync_behaviour = st.iface[`IF_ALTERNATE_SYNC_BEHAVIOUR];
    iface_out.output_drive_strength    = st.iface[`IF_DRIVE];
    iface_out.dout_reset               = st.iface[`IF_DOUT_RESET];
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_single_then_stop: assert property ( // RULE12
    st.done && (cur_mode == MODE_SINGLE) && !$past(wr_conv) |-> st.seq == SEQ_IDLE)
    else $error("single conversion did not stop");

  a_continuous_keeps_run: assert property ( // RULE1
    (st.seq == SEQ_RUN) && (st.cnt == 16'd0) && !wr_conv && (en_mask != 16'h0000)
      && (cur_mode == MODE_CONTINUOUS) |=> st.seq == SEQ_RUN && st.done)
    else $error("continuous mode stopped after a conversion");

  a_seq_next_channel: assert property ( // RULE7
    (st.seq == SEQ_RUN) && (st.cnt == 16'd0) && !wr_conv
      && (cur_mode == MODE_CONTINUOUS) && (en_mask != 16'h0000)
      |=> st.cur_ch == $past(nxt_ch))
    else $error("sequencer did not move to the next enabled channel");

  a_start_on_enabled: assert property ( // RULE6
    $rose(st.seq == SEQ_RUN) |-> en_mask[st.cur_ch] && $past(wr_conv))
    else $error("run began on a disabled channel or without a request");

  a_standby_halts: assert property ( // RULE2
    wr_conv && !starts_run(new_mode) |=> st.seq == SEQ_IDLE ##1 st.seq == SEQ_IDLE)
    else $error("standby or power-down did not halt conversion");

  a_ctrl_fields: assert property ( // RULE3
    wr_conv |=> conv_out.ref_enable == $past(pwdata[15])
      && conv_out.clock_source_select == $past(pwdata[3:2]))
    else $error("control fields not taken from the write");

  a_iface_fields: assert property ( // RULE5
    wr_access && (idx == `IDX_IFACE_CFG) |=> iface_out.short_word_length == $past(pwdata[0])
      && iface_out.continuous_read_enable == $past(pwdata[7]))
    else $error("interface fields not taken from the write");

  a_ref_from_setup: assert property ( // RULE4
    wr_access && (idx[5:3] == 3'b100) |=> st.ref_sel[$past(idx[2:0])] == $past(pwdata[5:4]))
    else $error("reference select shadow not updated");

  a_conv_period: assert property ( // RULE1
    $rose(st.seq == SEQ_RUN) && !wr_conv |-> !st.done [*8])
    else $error("conversion finished too early");

  a_idle_no_done: assert property ( // RULE12
    (st.seq == SEQ_IDLE) |=> !st.done)
    else $error("conversion ended while idle");

  c_continuous_wrap: cover property (
    st.done && (cur_mode == MODE_CONTINUOUS) ##1 st.cur_ch == low_ch);
  c_single_done: cover property (st.done && (cur_mode == MODE_SINGLE));
  c_bank_read: cover property (rd_access && in_bank);
  c_status_clear_race: cover property (st.done && rd_access && (idx == `IDX_STATUS));

endmodule

/* hdl/adc_seq_defs.svh */
`ifndef ADC_SEQ_DEFS_SVH
`define ADC_SEQ_DEFS_SVH

// register indices; byte address is four times the index
`define IDX_STATUS      6'h00
`define IDX_CONV_CTRL   6'h01
`define IDX_IFACE_CFG   6'h02
`define IDX_CHAN_BASE   6'h10
`define IDX_SETUP_CFG   6'h20
`define IDX_FILTER_CFG  6'h28
`define IDX_ZERO_COEF   6'h30
`define IDX_SCALE_COEF  6'h38

// reset values
`define RST_CONV_CTRL   16'ha000
`define RST_IFACE_CFG   16'h0000
`define RST_CHAN        16'h0000
`define RST_SETUP_CFG   24'h001320
`define RST_FILTER_CFG  24'h000500
`define RST_ZERO_COEF   24'h800000
`define RST_SCALE_COEF  24'h500000

// conversion_control fields
`define CC_REF_EN       15
`define CC_HIDE         14
`define CC_ONE_CYC      13
`define CC_DELAY_HI     10
`define CC_DELAY_LO     8
`define CC_MODE_HI      6
`define CC_MODE_LO      4
`define CC_CLK_HI       3
`define CC_CLK_LO       2

// interface_config fields
`define IF_ALTERNATE_SYNC_BEHAVIOUR     12
`define IF_DRIVE        11
`define IF_DOUT_RESET   8
`define IF_CONT_READ    7
`define IF_DATA_STAT    6
`define IF_REG_CHECK    5
`define IF_CRC_HI       3
`define IF_CRC_LO       2
`define IF_SHORT_WORD_LENGTH         0

// channel_register fields
`define CH_EN           15
`define CH_SETUP_HI     14
`define CH_SETUP_LO     12
`define CH_POS_HI       9
`define CH_POS_LO       5
`define CH_NEG_HI       4
`define CH_NEG_LO       0

// setup_configuration reference select field
`define SU_REF_HI       5
`define SU_REF_LO       4

// cycles of one conversion period
`define CONV_CYCLES     16'd16

`endif

/* hdl/adc_seq_pkg.sv */
package adc_seq_pkg;

  typedef enum logic [2:0] {
    MODE_CONTINUOUS = 3'h0,
    MODE_SINGLE     = 3'h1,
    MODE_STANDBY    = 3'h2,
    MODE_POWER_DOWN = 3'h3,
    MODE_INT_ZERO   = 3'h4,
    MODE_INT_SCALE  = 3'h5,
    MODE_SYS_ZERO   = 3'h6,
    MODE_SYS_SCALE  = 3'h7
  } conv_mode_t;

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b01,
    SEQ_RUN  = 2'b10
  } seq_state_t;

  typedef struct packed {
    conv_mode_t  mode;
    logic [1:0]  clock_source_select;
    logic        ref_enable;
    logic        conceal_settling_wait;
    logic        one_cycle_settling;
    logic [2:0]  settle_delay;
    logic [1:0]  ref_select;
    logic [3:0]  active_channel;
    logic [2:0]  active_setup;
    logic [4:0]  pos_input;
    logic [4:0]  neg_input;
    logic        converting;
    logic        conversion_done;
    logic        standby;
    logic        power_down;
    logic        calibrating;
  } conv_out_t;

  typedef struct packed {
    logic        short_word_length;
    logic [1:0]  checksum_mode;
    logic        append_status;
    logic        continuous_read_enable;
    logic        reg_check;
    logic        alternate_sync_behaviour;
    logic        output_drive_strength;
    logic        dout_reset;
  } iface_out_t;

endpackage

/* hdl/setup_bank.sv */
`timescale 1ns/10ps
`include "adc_seq_defs.svh"

// 32 words of setups: four groups of eight, registered read
module setup_bank
  import adc_seq_pkg::*;
#(
  parameter logic [23:0] SCALE_RESET = `RST_SCALE_COEF
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // write port
  input  wire logic        wr_en,
  input  wire logic [4:0]  wr_addr,
  input  wire logic [23:0] wr_data,
  // read port
  input  wire logic [4:0]  rd_addr,
  output logic      [23:0] rd_data
);

  typedef struct packed {
    logic [31:0][23:0] word;
    logic [23:0]       rd_data;
  } bank_state_t;

  bank_state_t st;
  bank_state_t next_st;

  // group of the word picks its power-on value
  function automatic logic [23:0] reset_word(input logic [4:0] a);
    logic [23:0] v;
    v = `RST_SETUP_CFG;
    case (a[4:3])
      2'd0:    v = `RST_SETUP_CFG;
      2'd1:    v = `RST_FILTER_CFG;
      2'd2:    v = `RST_ZERO_COEF;
      2'd3:    v = SCALE_RESET;
      default: v = `RST_SETUP_CFG;
    endcase
    return v;
  endfunction

  always_comb begin
    next_st         = st;
    next_st.rd_data = st.word[rd_addr];
    if (wr_en) begin
      next_st.word[wr_addr] = wr_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 32; i++) begin
        st.word[i] <= reset_word(5'(i));
      end
      st.rd_data <= 24'h000000;
    end else begin
      st <= next_st;
    end
  end

  assign rd_data = st.rd_data;

endmodule

/* tb/apb_host_model.sv */
`timescale 1ns/10ps

// host side of the register bus; the test programs all eight setups
module apb_host_model (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb master
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [7:0]  paddr,
  output logic      [31:0] pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
  end

  // call right after a rising edge; coefficient writes are optional
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // released lines must not keep showing the old request
    paddr  <= ~a;
    pwdata <= ~wd;
    // one idle edge, so a following call never drives a line twice at once
    @(posedge pclk);
  endtask
endmodule

/* tb/adc_mode_and_channel_sequencer_tb.sv */
`timescale 1ns/10ps
`include "adc_seq_defs.svh"

module adc_mode_and_channel_sequencer_tb
  import adc_seq_pkg::*;
;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  conv_out_t   conv_out;
  iface_out_t  iface_out;
  int          fail_count;
  int          cmp_count;
  int          cyc;
  logic [23:0] sc [8];
  logic [2:0]  su [16];
  logic [9:0]  pn [16];
  logic [31:0] r;
  logic [31:0] v;
  logic        e;
  int          nd;
  int          exp_ch [4] = '{9, 15, 2, 9};

  adc_mode_and_channel_sequencer u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .conv_out(conv_out), .iface_out(iface_out));

  apb_host_model u_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  task automatic chk_val(input string nm, input logic [31:0] x, input logic [31:0] g);
    cmp_count++;
    if (g !== x) begin
      fail_count++;
      $display("Error %s expected %h got %h", nm, x, g);
    end
  endtask

  task automatic chk_bit(input string nm, input logic x, input logic g);
    cmp_count++;
    if (g !== x) begin
      fail_count++;
      $display("Error %s expected %b got %b", nm, x, g);
    end
  endtask

  task automatic wr(input logic [5:0] i, input logic [31:0] d);
    logic [31:0] q;
    logic        f;
    u_host.xfer(1'b1, {i, 2'b00}, d, q, f);
  endtask

  task automatic rd(input logic [5:0] i, output logic [31:0] q);
    logic f;
    u_host.xfer(1'b0, {i, 2'b00}, 32'h0, q, f);
  endtask

  task automatic wait_done();
    int n;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (conv_out.conversion_done !== 1'b1 && n < 40);
  endtask

  task automatic final_report();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // hang guard, well above the few hundred cycles the tests need
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      final_report();
    end
  end

  initial begin
    presetn = 1'b0;
    void'($urandom(32'hbbf8));
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(`IDX_CONV_CTRL, r);
    chk_val("conv_ctrl reset", 32'h0000a000, r);
    chk_bit("ref_enable reset", 1'b1, conv_out.ref_enable);
    rd(`IDX_IFACE_CFG, r);
    chk_val("iface reset", 32'h0, r);
    v = {16'h0, 16'($urandom())};
    wr(`IDX_IFACE_CFG, v);
    rd(`IDX_IFACE_CFG, r);
    chk_val("iface readback", v, r);
    chk_bit("word length", v[`IF_SHORT_WORD_LENGTH], iface_out.short_word_length);
    chk_val("checksum", {30'h0, v[3:2]}, {30'h0, iface_out.checksum_mode});
    chk_bit("status append", v[`IF_DATA_STAT], iface_out.append_status);
    chk_bit("cont read", v[`IF_CONT_READ], iface_out.continuous_read_enable);
    chk_val("iface misc", {28'h0, v[12:11], v[8], v[5]},
            {28'h0, iface_out.alternate_sync_behaviour, iface_out.output_drive_strength,
             iface_out.dout_reset, iface_out.reg_check});
    u_host.xfer(1'b0, 8'h0c, 32'h0, r, e);
    chk_bit("unmapped err", 1'b1, e);
    chk_val("unmapped data", 32'h0, r);
    $display("registers reset and interface test done");
    for (int n = 0; n < 8; n++) begin
      sc[n] = 24'($urandom());
      v = {8'h0, 24'($urandom())};
      wr(6'(`IDX_SETUP_CFG + n), {8'h0, sc[n]});
      wr(6'(`IDX_FILTER_CFG + n), v);
      rd(6'(`IDX_SETUP_CFG + n), r);
      chk_val("setup cfg", {8'h0, sc[n]}, r);
      rd(6'(`IDX_FILTER_CFG + n), r);
      chk_val("filter cfg", v, r);
      rd(6'(`IDX_ZERO_COEF + n), r);
      chk_val("zero coef", {8'h0, `RST_ZERO_COEF}, r);
      rd(6'(`IDX_SCALE_COEF + n), r);
      chk_val("scale coef", {8'h0, `RST_SCALE_COEF}, r);
    end
    wr(6'(`IDX_SCALE_COEF + 7), 32'h00123456);
    rd(6'(`IDX_SCALE_COEF + 7), r);
    chk_val("scale write", 32'h00123456, r);
    $display("setup bank test done");
    // channels 2, 9, 15 enabled; the other 13 configured but left off
    for (int c = 0; c < 16; c++) begin
      su[c] = 3'($urandom());
      pn[c] = 10'($urandom());
      v = {16'h0, (c == 2 || c == 9 || c == 15), su[c], 2'b00, pn[c]};
      wr(6'(`IDX_CHAN_BASE + c), v);
    end
    wr(`IDX_CONV_CTRL, 32'h0000a000);
    @(posedge pclk);
    chk_val("first channel", 32'd2, {28'h0, conv_out.active_channel});
    chk_bit("converting", 1'b1, conv_out.converting);
    for (int k = 0; k < 4; k++) begin
      wait_done();
      chk_bit("done", 1'b1, conv_out.conversion_done);
      chk_val("next channel", exp_ch[k], {28'h0, conv_out.active_channel});
      chk_val("setup", {29'h0, su[exp_ch[k]]}, {29'h0, conv_out.active_setup});
      chk_val("ref sel", {30'h0, sc[su[exp_ch[k]]][5:4]}, {30'h0, conv_out.ref_select});
      chk_val("inputs", {22'h0, pn[exp_ch[k]]},
              {22'h0, conv_out.pos_input, conv_out.neg_input});
    end
    // status: ready sticky until read, running, current channel 9
    rd(`IDX_STATUS, r);
    chk_val("status", 32'h00000039, r);
    rd(`IDX_STATUS, r);
    chk_val("status cleared", 32'h00000019, r);
    $display("sequencer test done");
    for (int m = 0; m < 8; m++) begin
      v = {16'h0, 1'($urandom()), 8'($urandom()), 3'(m), 2'($urandom()), 2'b00};
      wr(`IDX_CONV_CTRL, v);
      rd(`IDX_CONV_CTRL, r);
      chk_val("conv_ctrl readback", v, r);
      chk_val("mode", m, {29'h0, conv_out.mode});
      chk_bit("ref_enable", v[15], conv_out.ref_enable);
      chk_val("clock sel", {30'h0, v[3:2]}, {30'h0, conv_out.clock_source_select});
      chk_bit("standby", m == 2, conv_out.standby);
      chk_bit("power down", m == 3, conv_out.power_down);
      chk_bit("calibrating", m >= 4, conv_out.calibrating);
      chk_val("settle fields", {27'h0, v[14:13], v[10:8]},
              {27'h0, conv_out.conceal_settling_wait, conv_out.one_cycle_settling,
               conv_out.settle_delay});
      if (m == 2 || m == 3)
        chk_bit("stopped", 1'b0, conv_out.converting);
    end
    $display("mode test done");
    wr(`IDX_CONV_CTRL, 32'h0000a010);
    wait_done();
    chk_bit("single done", 1'b1, conv_out.conversion_done);
    nd = 0;
    repeat (60) begin
      @(posedge pclk);
      if (conv_out.conversion_done === 1'b1)
        nd++;
    end
    chk_val("extra dones", 32'd0, nd);
    chk_bit("single idle", 1'b0, conv_out.converting);
    $display("single conversion test done");
    // reset in the middle of a continuous run
    wr(`IDX_CONV_CTRL, 32'h0000a000);
    repeat (5) @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk_bit("reset halts", 1'b0, conv_out.converting);
    rd(`IDX_CONV_CTRL, r);
    chk_val("conv_ctrl re-reset", 32'h0000a000, r);
    wr(`IDX_CONV_CTRL, 32'h0000a000);
    chk_bit("no channel start", 1'b0, conv_out.converting);
    $display("mid-run reset test done");
    final_report();
  end
endmodule
